//--- hw/iid_decode_regfile.sv
// Integer instruction decoder with the general register file and product registers.
// Assumes fetch holds an instruction until it is taken and later stages write back via wb_*.

// Behaviour
// - Every instruction is one 32-bit word in one of three formats.
// - Loads and stores are I format; address is base plus sign-extended offset.
// - Register computes are R format; immediate computes are I format.
// - Computes name two sources and a separate destination.
// - Jump target joins the 26-bit field with the upper four PC bits.
// - Register jumps take the full target from the named register.
// - Branches are I format; target is PC plus 4 plus the 16-bit offset shifted left by two.
// - JAL and link branches write the return address to link_register; register link jumps write it to rd.
// - Coprocessor loads and stores are I format; operations are coprocessor defined.
// - Coprocessor condition branches sample the branch condition pins.
// - Condition input one comes from the float coprocessor, not a pin.
// - Special instructions are always decoded as R format.
// - Access sizes are word 32, halfword 16 and byte 8 bits.
// - Endianness is latched at reset; big-endian byte 0 is the top lane.
// - Little-endian byte 0 is the bottom lane.
// - Halfwords need even addresses and words addresses divisible by four.
// - Item address names its top byte in big-endian, bottom byte in little.
// - Left and right partial word accesses pair to reach a misaligned word.
// - Thirty-two general registers of 32 bits each.
// - hardwired_zero_reg reads zero and discards writes.
// - link_register is an ordinary register outside link instructions.
// - Product registers hold multiply product or divide quotient and remainder.
// - Reads of product registers stall until the multiply or divide completes.
// - Loaded data is not visible to the next instruction and is not interlocked.
// - Control transfer takes effect after the following delay-slot instruction.
module iid_decode_regfile
  import iid_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Asynchronous pins
  input  wire logic             big_endian_pin,
  input  wire logic [NCOND-1:0] branch_condition_input,
  // Float coprocessor condition
  input  wire logic             float_cond,
  // Fetch side
  input  wire logic             instr_valid,
  input  wire logic [31:0]      instr_word,
  input  wire logic [31:0]      instr_pc,
  output logic                  instr_ready,
  // Write back from later stages
  input  wire logic             wb_we,
  input  wire logic [4:0]       wb_reg,
  input  wire logic [31:0]      wb_data,
  // Multiply and divide unit
  input  wire logic             mdu_done,
  input  wire logic [31:0]      mdu_hi,
  input  wire logic [31:0]      mdu_lo,
  output logic                  mdu_start,
  output logic [1:0]            mdu_func,
  // Decoded instruction
  output logic                  dec_valid,
  output iid_fmt_e              dec_fmt,
  output iid_grp_e              dec_group,
  output logic [5:0]            dec_opcode,
  output logic [5:0]            dec_funct,
  output logic [4:0]            dec_shamt,
  output logic [4:0]            dest_reg,
  output logic                  dest_we,
  output logic [31:0]           src_a,
  output logic [31:0]           src_b,
  // Control transfer
  output logic                  redirect,
  output logic [31:0]           redirect_pc,
  // Data memory
  output logic                  mem_req,
  output logic                  mem_we,
  output logic [31:0]           mem_addr,
  output logic [3:0]            mem_be,
  output logic [31:0]           mem_wdata,
  output iid_size_e             mem_size,
  output logic                  mem_signed,
  output logic                  addr_error,
  // Mode
  output logic                  big_endian
);

  logic [31:0]    rf [NREG];
  logic [31:0]    hi_r;
  logic [31:0]    lo_r;
  logic           mdu_busy_r;
  logic           pend_v_r;
  logic [31:0]    pend_r;
  logic [31:0]    pend_pc_r;
  logic [NCOND:0] s1_r;
  logic [NCOND:0] s2_r;
  logic [NCOND:0] s3_r;
  logic [NCOND:0] filt_r;

  // General register read; the zero register never returns stored data.
  function automatic logic [31:0] rd_gpr(input logic [4:0] idx);
    rd_gpr = (idx == REG_ZERO) ? '0 : rf[idx];
  endfunction : rd_gpr

  // Pins cross with three flops; a level counts once stages two and three agree.
  always_ff @(posedge sys_clk)
  begin
    s1_r   <= {big_endian_pin, branch_condition_input};
    s2_r   <= s1_r;
    s3_r   <= s2_r;
    filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
  end

  // Byte order follows the strap while reset is held and freezes at release.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      big_endian <= filt_r[NCOND];
  end

  wire [NCOND-1:0] cond_vec = (filt_r[NCOND-1:0] & ~FPU_COND_MASK)
                            | ({NCOND{float_cond}} & FPU_COND_MASK);

  // Current instruction: a parked product reader takes precedence over fetch.
  wire [31:0] cur    = pend_v_r ? pend_r : instr_word;
  wire [31:0] cur_pc = pend_v_r ? pend_pc_r : instr_pc;
  wire [5:0]  op     = cur[OPC_HI:OPC_LO];
  wire [4:0]  rs     = cur[RS_HI:RS_LO];
  wire [4:0]  rt     = cur[RT_HI:RT_LO];
  wire [4:0]  rd     = cur[RD_HI:RD_LO];
  wire [5:0]  fn     = cur[FN_HI:FN_LO];
  wire [15:0] imm    = cur[IMM_HI:0];
  wire [31:0] rs_val = rd_gpr(rs);
  wire [31:0] rt_val = rd_gpr(rt);

  wire is_special = (op == OP_SPECIAL);
  wire is_regimm  = (op == OP_REGIMM);
  wire is_j       = (op == OP_J) || (op == OP_JAL);
  wire is_alu_imm = (op[5:3] == OPG_ALUI);
  wire is_load    = (op[5:3] == OPG_LOAD);
  wire is_store   = (op[5:3] == OPG_STORE);
  wire is_cop_ls  = (op[5:3] == OPG_LWC) || (op[5:3] == OPG_SWC);
  wire is_cop     = (op[5:2] == OPG_COP);
  wire is_bc      = is_cop && (rs == COP_RS_BC);
  wire is_jr      = is_special && ((fn == FN_JR) || (fn == FN_JUMP_REGISTER_WITH_LINK));
  wire is_hilo_rd = is_special && ((fn == FN_MFHI) || (fn == FN_MFLO));
  wire is_hilo_wr = is_special && ((fn == FN_MTHI) || (fn == FN_MTLO));
  wire is_sys     = is_special && ((fn == FN_SYSCALL) || (fn == FN_BREAK));
  wire is_muldiv  = is_special && (fn[5:2] == FNG_MULDIV);
  wire is_cbr     = (op == OP_BEQ) || (op == OP_BNE) || (op == OP_BLEZ) || (op == OP_BGTZ);
  wire is_mem     = is_load || is_store || is_cop_ls;
  wire is_wr      = is_store || (op[5:3] == OPG_SWC);
  wire sp_alu     = is_special && !is_jr && !is_hilo_rd && !is_hilo_wr && !is_sys && !is_muldiv;

  // Three formats; coprocessor operations keep their own layout, reported under R.
  wire iid_fmt_e fmt_nxt = is_j ? FMT_J :
                           (is_special || (is_cop && !is_bc)) ? FMT_R :
                           FMT_I;

  wire iid_grp_e grp_nxt = (is_load || is_store) ? GRP_LDST :
                           (is_cop || is_cop_ls) ? GRP_COP :
                           (is_j || is_jr || is_regimm || is_cbr) ? GRP_JMPBR :
                           (is_hilo_rd || is_hilo_wr || is_sys) ? GRP_SPEC :
                           GRP_COMP;

  // Immediates.
  wire [31:0] imm_s   = {{16{imm[IMM_HI]}}, imm};
  wire [31:0] imm_z   = {16'h0000, imm};
  wire [31:0] imm_u   = {imm, 16'h0000};
  wire        logic_i = (op[5:2] == OPG_LOGI) && (op != OP_LUI);
  wire [31:0] src_b_nxt = !is_alu_imm ? rt_val :
                          (op == OP_LUI) ? imm_u : logic_i ? imm_z : imm_s;

  // Multiply and divide interlock.
  wire busy     = mdu_busy_r && !mdu_done;
  wire take_new = instr_valid && instr_ready && !pend_v_r;
  wire park     = take_new && is_hilo_rd && busy;
  wire issue    = pend_v_r ? !busy : (take_new && !park);
  wire pend_nxt = park || (pend_v_r && busy);
  wire [31:0] hi_src = mdu_done ? mdu_hi : hi_r;
  wire [31:0] lo_src = mdu_done ? mdu_lo : lo_r;

  // Control transfer; the fetch unit still runs the delay-slot instruction.
  wire [31:0] pc_next = cur_pc + PC_STEP;
  wire [31:0] j_tgt   = {pc_next[31:PAGE_LO], cur[TGT_HI:0], 2'b00};
  wire [31:0] b_tgt   = pc_next + {imm_s[29:0], 2'b00};
  wire        eq      = (rs_val == rt_val);
  wire        neg     = rs_val[XLEN-1];
  wire        zero    = (rs_val == '0);
  wire        bc_hit  = (cond_vec[op[1:0]] == rt[RT_TF_BIT - RT_LO]);
  wire        br_take = ((op == OP_BEQ) && eq) || ((op == OP_BNE) && !eq)
                     || ((op == OP_BLEZ) && (neg || zero))
                     || ((op == OP_BGTZ) && !neg && !zero)
                     || (is_regimm && (rt[0] ? !neg : neg))
                     || (is_bc && bc_hit);
  wire        taken   = is_j || is_jr || br_take;
  wire [31:0] tgt     = is_j ? j_tgt : is_jr ? rs_val : b_tgt;

  // Link writes and product-register reads (MFHI, MFLO) write the file inside the decoder.
  wire       link_en  = (op == OP_JAL) || (is_special && (fn == FN_JUMP_REGISTER_WITH_LINK))
                     || (is_regimm && rt[RT_LINK_BIT - RT_LO]);
  wire [4:0] link_dst = (op == OP_JAL || is_regimm) ? REG_LINK : rd;
  wire        iw_en   = issue && (link_en || is_hilo_rd);
  wire [4:0]  iw_addr = link_en ? link_dst : rd;
  wire [31:0] iw_data = link_en ? (cur_pc + LINK_OFFSET) :
                        (fn == FN_MFHI) ? hi_src : lo_src;

  // Memory access: address, size, lanes and alignment.
  wire [31:0] ea      = rs_val + imm_s;
  wire [1:0]  a       = ea[1:0];
  wire [1:0]  ln      = big_endian ? ~a : a;
  wire        part    = !is_cop_ls && (op[1:0] == LS_PART);
  wire        left    = part && !op[2];
  wire iid_size_e sz  = is_cop_ls ? SZ_WORD :
                        (op[1:0] == LS_BYTE) ? SZ_BYTE :
                        (op[1:0] == LS_HALF) ? SZ_HALF : SZ_WORD;
  wire        misal   = !part && (((sz == SZ_HALF) && a[0])
                     || ((sz == SZ_WORD) && (a != 2'b00)));
  wire [3:0]  be_nxt  = part ? (left ? (BE_ALL >> ~ln) : (BE_ALL << ln)) :
                        (sz == SZ_BYTE) ? (BE_BYTE << ln) :
                        (sz == SZ_HALF) ? (BE_HALF << {ln[1], 1'b0}) : BE_ALL;
  wire [31:0] wd_nxt  = part ? (left ? (rt_val >> {~ln, 3'b000}) : (rt_val << {ln, 3'b000})) :
                        (sz == SZ_BYTE) ? {4{rt_val[7:0]}} :
                        (sz == SZ_HALF) ? {2{rt_val[15:0]}} : rt_val;
  wire        mem_ok  = issue && is_mem && !misal;

  // Destinations written back later by execute or memory; a load result lands
  // after the next instruction has read its sources, with no interlock.
  wire [4:0] dst_nxt = (is_special || is_cop) ? rd : rt;
  wire       dwe_nxt = issue && (sp_alu || is_alu_imm || (is_load && !misal));

  // General register file; register zero is a constant.
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : gen_rf
      if (g == 0)
      begin : gen_zero
        always_ff @(posedge sys_clk)
          rf[g] <= '0;
      end
      else
      begin : gen_reg
        always_ff @(posedge sys_clk)
        begin
          if (!nrst)
            rf[g] <= '0;
          else if (iw_en && (iw_addr == 5'(g)))
            rf[g] <= iw_data;
          else if (wb_we && (wb_reg == 5'(g)))
            rf[g] <= wb_data;
        end
      end
    end
  endgenerate

  // Product registers and interlock state.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      hi_r       <= '0;
      lo_r       <= '0;
      mdu_busy_r <= 1'b0;
      pend_v_r   <= 1'b0;
      pend_r     <= '0;
      pend_pc_r  <= '0;
      instr_ready <= 1'b0;
    end
    else
    begin
      hi_r        <= (issue && is_special && (fn == FN_MTHI)) ? rs_val : hi_src;
      lo_r        <= (issue && is_special && (fn == FN_MTLO)) ? rs_val : lo_src;
      mdu_busy_r  <= (issue && is_muldiv) || busy;
      pend_v_r    <= pend_nxt;
      pend_r      <= cur;
      pend_pc_r   <= cur_pc;
      instr_ready <= !pend_nxt;
    end
  end

  // Registered decode, control and memory outputs.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      dec_valid   <= 1'b0;
      dec_fmt     <= FMT_I;
      dec_group   <= GRP_LDST;
      dec_opcode  <= '0;
      dec_funct   <= '0;
      dec_shamt   <= '0;
      dest_reg    <= '0;
      dest_we     <= 1'b0;
      src_a       <= '0;
      src_b       <= '0;
      mdu_start   <= 1'b0;
      mdu_func    <= '0;
      redirect    <= 1'b0;
      redirect_pc <= '0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= '0;
      mem_be      <= '0;
      mem_wdata   <= '0;
      mem_size    <= SZ_BYTE;
      mem_signed  <= 1'b0;
      addr_error  <= 1'b0;
    end
    else
    begin
      dec_valid   <= issue;
      dec_fmt     <= fmt_nxt;
      dec_group   <= grp_nxt;
      dec_opcode  <= op;
      dec_funct   <= fn;
      dec_shamt   <= cur[SH_HI:SH_LO];
      dest_reg    <= dst_nxt;
      dest_we     <= dwe_nxt;
      src_a       <= rs_val;
      src_b       <= src_b_nxt;
      mdu_start   <= issue && is_muldiv;
      mdu_func    <= fn[1:0];
      redirect    <= issue && taken;
      redirect_pc <= tgt;
      mem_req     <= mem_ok;
      mem_we      <= mem_ok && is_wr;
      mem_addr    <= ea;
      mem_be      <= be_nxt;
      mem_wdata   <= wd_nxt;
      mem_size    <= sz;
      mem_signed  <= is_load && !op[2];
      addr_error  <= issue && is_mem && misal;
    end
  end

endmodule : iid_decode_regfile

//--- hw/iid_pkg.sv
// Shared constants and types for the integer instruction decoder and register file.
// Assumes a 32-bit fixed-length instruction set with three basic formats.
package iid_pkg;

  localparam int          XLEN      = 32;
  localparam int          NREG      = 32;
  localparam int          NCOND     = 4;
  localparam logic [4:0]  REG_ZERO  = 5'h00;
  localparam logic [4:0]  REG_LINK  = 5'h1f;

  // Instruction field positions.
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int RS_HI  = 25;
  localparam int RS_LO  = 21;
  localparam int RT_HI  = 20;
  localparam int RT_LO  = 16;
  localparam int RD_HI  = 15;
  localparam int RD_LO  = 11;
  localparam int SH_HI  = 10;
  localparam int SH_LO  = 6;
  localparam int FN_HI  = 5;
  localparam int FN_LO  = 0;
  localparam int IMM_HI = 15;
  localparam int TGT_HI = 25;
  localparam int PAGE_LO = 28;
  localparam int RT_LINK_BIT = 20;
  localparam int RT_TF_BIT   = 16;

  // Major opcodes.
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_REGIMM  = 6'h01;
  localparam logic [5:0] OP_J       = 6'h02;
  localparam logic [5:0] OP_JAL     = 6'h03;
  localparam logic [5:0] OP_BEQ     = 6'h04;
  localparam logic [5:0] OP_BNE     = 6'h05;
  localparam logic [5:0] OP_BLEZ    = 6'h06;
  localparam logic [5:0] OP_BGTZ    = 6'h07;
  localparam logic [5:0] OP_LUI     = 6'h0f;
  localparam logic [2:0] OPG_ALUI   = 3'h1;
  localparam logic [3:0] OPG_LOGI   = 4'h3;
  localparam logic [3:0] OPG_COP    = 4'h4;
  localparam logic [2:0] OPG_LOAD   = 3'h4;
  localparam logic [2:0] OPG_STORE  = 3'h5;
  localparam logic [2:0] OPG_LWC    = 3'h6;
  localparam logic [2:0] OPG_SWC    = 3'h7;
  localparam logic [1:0] LS_BYTE    = 2'h0;
  localparam logic [1:0] LS_HALF    = 2'h1;
  localparam logic [1:0] LS_PART    = 2'h2;
  localparam logic [4:0] COP_RS_BC  = 5'h08;
  localparam logic [3:0] FPU_COND_MASK = 4'h2;

  // Special-group function codes.
  localparam logic [5:0] FN_JR      = 6'h08;
  localparam logic [5:0] FN_JUMP_REGISTER_WITH_LINK    = 6'h09;
  localparam logic [5:0] FN_SYSCALL = 6'h0c;
  localparam logic [5:0] FN_BREAK   = 6'h0d;
  localparam logic [5:0] FN_MFHI    = 6'h10;
  localparam logic [5:0] FN_MTHI    = 6'h11;
  localparam logic [5:0] FN_MFLO    = 6'h12;
  localparam logic [5:0] FN_MTLO    = 6'h13;
  localparam logic [3:0] FNG_MULDIV = 4'h6;

  localparam logic [31:0] PC_STEP     = 32'h0000_0004;
  localparam logic [31:0] LINK_OFFSET = 32'h0000_0008;
  localparam logic [3:0]  BE_BYTE     = 4'h1;
  localparam logic [3:0]  BE_HALF     = 4'h3;
  localparam logic [3:0]  BE_ALL      = 4'hf;

  typedef enum logic [1:0] {
    FMT_I = 2'b00,
    FMT_R = 2'b01,
    FMT_J = 2'b10
  } iid_fmt_e;

  typedef enum logic [2:0] {
    GRP_LDST  = 3'b000,
    GRP_COMP  = 3'b001,
    GRP_JMPBR = 3'b010,
    GRP_COP   = 3'b011,
    GRP_SPEC  = 3'b100
  } iid_grp_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } iid_size_e;

endpackage : iid_pkg

//--- bench/iid_mdu_model.sv
// Behavioural multiply and divide unit that answers the decoder.
// Assumes operands arrive on src_a and src_b together with the mdu_start pulse.
module iid_mdu_model
  import iid_pkg::*;
#(
  parameter int LAT = 6
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Request
  input  wire logic        mdu_start,
  input  wire logic [1:0]  mdu_func,
  input  wire logic [31:0] src_a,
  input  wire logic [31:0] src_b,
  // Result
  output logic             mdu_done = 1'b0,
  output logic [31:0]      mdu_hi   = 32'h0,
  output logic [31:0]      mdu_lo   = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt;
  logic [63:0] res;
  // Results flip outside the done pulse, so a late sample cannot pass by luck.
  always @(posedge sys_clk)
  begin
    mdu_done <= 1'b0;
    mdu_hi   <= ~mdu_hi;
    mdu_lo   <= ~mdu_lo;
    if (!nrst)
      cnt <= 0;
    else if (mdu_start)
    begin
      cnt <= LAT;
      res <= mdu_func[1] ? {src_a % src_b, src_a / src_b} : 64'(src_a) * 64'(src_b);
    end
    else if (cnt == 1)
    begin
      cnt               <= 0;
      mdu_done          <= 1'b1;
      {mdu_hi, mdu_lo}  <= res;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : iid_mdu_model

//--- bench/iid_decode_regfile_assertions.sv
// Concurrent checks on the decoder's ports.
// Assumes one clock domain with the synchronous active-low reset.
module iid_decode_regfile_checker
  import iid_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Fetch and product unit
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic        mdu_done,
  // Decode and control transfer
  input wire logic        dec_valid,
  input wire iid_fmt_e    dec_fmt,
  input wire iid_grp_e    dec_group,
  input wire logic [31:0] src_a,
  input wire logic        redirect,
  input wire logic [31:0] redirect_pc,
  // Memory
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0]  mem_be,
  input wire iid_size_e   mem_size,
  input wire logic        addr_error,
  input wire logic        big_endian
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic        taken_r;
  logic [31:0] word_r;
  logic [31:0] pc_r;
  wire  [31:0] seq_pc = pc_r + PC_STEP;
  wire  [31:0] br_off = {{14{word_r[15]}}, word_r[15:0], 2'b00};
  wire  [1:0]  lo2    = mem_addr[1:0];
  // The taken word is kept so each answer can be tied to its cause.
  always_ff @(posedge sys_clk)
  begin
    taken_r <= nrst & instr_valid & instr_ready;
    word_r  <= instr_word;
    pc_r    <= instr_pc;
  end
  a_issue_next: assert property (instr_valid && instr_ready
    && instr_word[31:26] != OP_SPECIAL |=> dec_valid) else $error("decode answer missing");
  a_zero_src: assert property (taken_r && dec_valid && word_r[25:21] == REG_ZERO
    |-> src_a == 32'h0) else $error("zero register read nonzero");
  a_load_fmt: assert property (taken_r && dec_valid && word_r[31:29] == OPG_LOAD
    |-> dec_fmt == FMT_I && dec_group == GRP_LDST) else $error("load decoded wrongly");
  a_special_fmt: assert property (taken_r && dec_valid && word_r[31:26] == OP_SPECIAL
    |-> dec_fmt == FMT_R) else $error("special group not register format");
  a_jump_page: assert property (taken_r && word_r[31:27] == 5'h01 |-> redirect
    && redirect_pc == {seq_pc[31:28], word_r[25:0], 2'b00}) else $error("jump target wrong");
  a_branch_rel: assert property (taken_r && word_r[31:16] == {OP_BEQ, 10'h0} |-> redirect
    && redirect_pc == seq_pc + br_off) else $error("branch target wrong");
  a_byte_lane: assert property (mem_req && mem_size == SZ_BYTE
    |-> mem_be == (big_endian ? 4'h8 >> lo2 : 4'h1 << lo2)) else $error("byte lane wrong");
  a_half_lane: assert property (mem_req && mem_size == SZ_HALF |-> !lo2[0]
    && mem_be == (big_endian ? 4'hc >> lo2 : 4'h3 << lo2)) else $error("half lane wrong");
  a_err_no_req: assert property (addr_error |-> !mem_req)
    else $error("misaligned access performed");
  a_mf_stall: assert property (!instr_ready && !mdu_done |=> !dec_valid)
    else $error("parked read issued early");
  c_stall: cover property (!instr_ready && mdu_done);
  c_addr_err: cover property (addr_error);
  c_redirect: cover property (taken_r && redirect);
endmodule : iid_decode_regfile_checker

bind iid_decode_regfile iid_decode_regfile_checker i_iid_decode_regfile_checker (.*);

//--- bench/integer_isa_decode_regfile_test.sv
// Self-checking bench for the decoder and register file.
// Assumes the product unit model stands on the far side of mdu_*.
module integer_isa_decode_regfile_test
  import iid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] w; iid_fmt_e f; iid_grp_e g; logic [31:0] a, b;} iid_row_s;
  logic        sys_clk = 0, nrst = 0, big_endian_pin = 1, float_cond = 0;
  logic        instr_valid = 0, wb_we = 0;
  logic [3:0]  branch_condition_input = 4'h6;
  logic [31:0] instr_word = 0, instr_pc = 0, wb_data = 0;
  logic [4:0]  wb_reg = 0;
  logic        instr_ready, mdu_done, mdu_start, dec_valid, dest_we, redirect;
  logic        mem_req, mem_we, mem_signed, addr_error, big_endian;
  logic [31:0] mdu_hi, mdu_lo, src_a, src_b, redirect_pc, mem_addr, mem_wdata;
  logic [1:0]  mdu_func;
  iid_fmt_e    dec_fmt;
  iid_grp_e    dec_group;
  logic [5:0]  dec_opcode, dec_funct;
  logic [4:0]  dec_shamt, dest_reg;
  logic [3:0]  mem_be;
  iid_size_e   mem_size;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0, n;
  logic [31:0] bw [5] = '{32'h45010004, 32'h45010004, 32'h45000004, 32'h49010004, 32'h4d010004};
  iid_row_s    rows [9] = '{
    '{32'h00221821, FMT_R, GRP_COMP, 32'h1000, 32'h5},
    '{32'h2424fffc, FMT_I, GRP_COMP, 32'h1000, 32'hfffffffc},
    '{32'h34048001, FMT_I, GRP_COMP, 32'h0, 32'h8001},
    '{32'h3c051234, FMT_I, GRP_COMP, 32'h0, 32'h12340000},
    '{32'h8c260008, FMT_I, GRP_LDST, 32'h1000, 32'h0},
    '{32'hc4200004, FMT_I, GRP_COP, 32'h1000, 32'h0},
    '{32'h0000000c, FMT_R, GRP_SPEC, 32'h0, 32'h0},
    '{32'h08100040, FMT_J, GRP_JMPBR, 32'h0, 32'h0},
    '{32'h00200011, FMT_R, GRP_SPEC, 32'h1000, 32'h0}};

  iid_decode_regfile i_iid_decode_regfile (.*);
  iid_mdu_model      i_iid_mdu_model (.*);

  initial forever #4 sys_clk = ~sys_clk;
  // A hang is cut short well beyond the hundred or so cycles the run needs.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // Returns just after the taking edge, while that instruction's pulses stand.
  task automatic issue(input logic [31:0] w);
    logic rdy;
    @(posedge sys_clk);
    #1;
    instr_valid = 1;
    instr_word  = w;
    do
    begin
      rdy = instr_ready;
      @(posedge sys_clk);
      #1;
    end
    while (!rdy);
    instr_valid = 0;
  endtask : issue

  task automatic wb(input logic [4:0] r, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    wb_we   = 1;
    wb_reg  = r;
    wb_data = d;
    @(posedge sys_clk);
    #1;
    wb_we = 0;
  endtask : wb

  // The strap needs five edges to pass its synchroniser and filter and reach big_endian.
  task automatic rst(input logic pin);
    @(posedge sys_clk);
    #1;
    nrst           = 0;
    big_endian_pin = pin;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("instr_ready", instr_ready, 0);
    nrst = 1;
    @(posedge sys_clk);
    #1;
    chk("big_endian", big_endian, pin);
    wb(1, 32'h1000);
    wb(2, 32'h5);
  endtask : rst

  task automatic mem(input logic e);
    logic [31:0] mw [4] = '{32'ha0220001, 32'ha4220002, 32'ha4220003, 32'h88260001};
    logic [15:0] bx;
    bx = e ? 16'h4307 : 16'h2c03;
    for (int k = 0; k < 4; k++)
    begin
      issue(mw[k]);
      chk("addr_error", addr_error, k == 2);
      chk("mem_req", mem_req, k != 2);
      if (k != 2)
      begin
        chk("mem_be", mem_be, bx[15-4*k -: 4]);
        chk("mem_addr", mem_addr, 32'h1000 + mw[k][15:0]);
        chk("mem_we", mem_we, k < 2);
        chk("mem_size", mem_size, (k == 0) ? SZ_BYTE : (k == 1) ? SZ_HALF : SZ_WORD);
        chk("mem_wdata", mem_wdata, (k == 0) ? 32'h05050505 : (k == 1) ? 32'h00050005 : 32'h0);
      end
    end
  endtask : mem

  initial
  begin
    rst(1);
    wb(31, 32'hcafe0001);
    wb(0, 32'hffffffff);
    instr_pc = 32'h00400010;
    foreach (rows[i])
    begin
      issue(rows[i].w);
      chk("dec_valid", dec_valid, 1);
      chk("dec_fmt", dec_fmt, rows[i].f);
      chk("dec_group", dec_group, rows[i].g);
      chk("src_a", src_a, rows[i].a);
      chk("src_b", src_b, rows[i].b);
    end
    instr_pc = 32'h90000100;
    issue(32'h03e00008);
    chk("redirect_pc", redirect_pc, 32'hcafe0001);
    issue(32'h0c123456);
    chk("redirect_pc", redirect_pc, 32'h9048d158);
    issue(32'h03e03821);
    chk("src_a", src_a, 32'h90000108);
    chk("dest_reg", dest_reg, 7);
    chk("dest_we", dest_we, 1);
    chk("dec_opcode", dec_opcode, 0);
    chk("dec_funct", dec_funct, 32'h21);
    issue(32'h1000ffff);
    chk("redirect_pc", redirect_pc, 32'h90000100);
    for (int k = 0; k < 5; k++)
    begin
      float_cond = (k == 0);
      repeat (4) @(posedge sys_clk);
      issue(bw[k]);
      chk("redirect", redirect, 5'b01101 >> k & 1);
    end
    issue(32'h00220018);
    chk("mdu_start", mdu_start, 1);
    chk("mdu_func", mdu_func, 0);
    issue(32'h00004012);
    chk("dec_valid", dec_valid, 0);
    n = 0;
    while (dec_valid !== 1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("dec_valid", dec_valid, 1);
    issue(32'h01004821);
    chk("src_a", src_a, 32'h5000);
    mem(1);
    rst(0);
    mem(0);
    results();
  end
endmodule : integer_isa_decode_regfile_test
